// file: core/analog_comparator_control.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module analog_comparator_control (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire acmp_pkg::addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_raw,
  input wire logic converter_enable,
  input wire logic [2:0] channel_select,
  input wire logic global_irq_enable,
  input wire logic vector_ack,
  output logic comparator_power_off,
  output logic bandgap_select,
  output logic neg_from_converter,
  output logic [2:0] neg_channel,
  output logic capture_trigger,
  output logic [2:0] trigger_select,
  output logic compare_irq,
  output logic irq
);
  import acmp_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  csr_t csr;
  csr_t next_csr;
  ctlb_t ctlb;
  ctlb_t next_ctlb;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic compare_result;
  logic result_rise;
  logic result_fall;
  logic mode_event;
  logic next_neg_conv;
  logic [2:0] next_neg_ch;
  logic next_capture;
  logic hit;
  logic access;
  logic wr_csr;
  logic wr_ctlb;
  logic wr_stat;
  logic wr_mask;

  // ----------------------------------------
  // synchroniser and edge detection
  // ----------------------------------------
  // the raw comparator is asynchronous to ref_clk, hence two stages
  sync_chain #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(comparator_raw),
    .sync_out(compare_result)
  );

  edge_detect u_edge (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .level(compare_result),
    .rise(result_rise),
    .fall(result_fall)
  );

  // reserved mode never fires; mode changes are not filtered here
  always_comb begin
    case (csr.mode)
      MODE_TOGGLE: begin
        mode_event = result_rise | result_fall;
      end
      MODE_FALL: begin
        mode_event = result_fall;
      end
      MODE_RISE: begin
        mode_event = result_rise;
      end
      default: begin
        mode_event = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign pready = 1'b1;
  assign access = psel & penable;
  always_comb begin
    case (paddr)
      CSR_ADDR, CTLB_ADDR, IRQ_STAT_ADDR, IRQ_MASK_ADDR: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end
  assign pslverr = access & ~hit;
  assign wr_csr = access & pwrite & (paddr == CSR_ADDR);
  assign wr_ctlb = access & pwrite & (paddr == CTLB_ADDR);
  assign wr_stat = access & pwrite & (paddr == IRQ_STAT_ADDR);
  assign wr_mask = access & pwrite & (paddr == IRQ_MASK_ADDR);

  // read data is captured in the setup phase and held through access
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        CSR_ADDR: begin
          next_prdata[7:0] = {csr.power_off, csr.bandgap, compare_result,
                              csr.flag, csr.irq_en, csr.capture_en, csr.mode};
        end
        CTLB_ADDR: begin
          next_prdata[7:0] = {1'b0, ctlb.mux_en, 3'h0, ctlb.trig};
        end
        IRQ_STAT_ADDR: begin
          next_prdata[IRQ_W-1:0] = irq_status;
        end
        IRQ_MASK_ADDR: begin
          next_prdata[IRQ_W-1:0] = irq_mask;
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // control/status register
  // ----------------------------------------
  always_comb begin
    next_csr = csr;
    if (wr_csr) begin
      next_csr.power_off = pwdata[BIT_POWER_OFF];
      next_csr.bandgap = pwdata[BIT_BANDGAP];
      next_csr.irq_en = pwdata[BIT_IRQ_EN];
      next_csr.capture_en = pwdata[BIT_CAPTURE];
      next_csr.mode = mode_t'(pwdata[1:0]);
    end
    // result bit has no storage, so writes to it vanish
    if ((wr_csr && pwdata[BIT_FLAG]) || vector_ack) begin
      next_csr.flag = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (mode_event) begin
      next_csr.flag = 1'b1;
    end
  end

  always_comb begin
    next_ctlb = ctlb;
    if (wr_ctlb) begin
      next_ctlb.mux_en = pwdata[BIT_MUX_EN];
      next_ctlb.trig = pwdata[2:0];
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  always_comb begin
    next_irq_status = irq_status;
    if (wr_stat) begin
      next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
    end
    next_irq_status[IRQ_EVENT] = next_irq_status[IRQ_EVENT] | mode_event;
    next_irq_status[IRQ_CHANGE] = next_irq_status[IRQ_CHANGE] | result_rise | result_fall;
    next_irq_mask = irq_mask;
    if (wr_mask) begin
      next_irq_mask = pwdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // analog steering and capture route
  // ----------------------------------------
  // converter mux only borrowed while the converter itself is off
  always_comb begin
    next_neg_conv = ctlb.mux_en & ~converter_enable;
    next_neg_ch = next_neg_conv ? channel_select : 3'h0;
    next_capture = csr.capture_en & compare_result;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      csr <= CSR_RESET;
      ctlb <= CTLB_RESET;
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      prdata <= 32'h0000_0000;
      neg_from_converter <= 1'b0;
      neg_channel <= 3'h0;
      capture_trigger <= 1'b0;
    end else begin
      csr <= next_csr;
      ctlb <= next_ctlb;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
      neg_from_converter <= next_neg_conv;
      neg_channel <= next_neg_ch;
      capture_trigger <= next_capture;
    end
  end

  assign comparator_power_off = csr.power_off;
  assign bandgap_select = csr.bandgap;
  assign trigger_select = ctlb.trig;
  assign compare_irq = csr.flag & csr.irq_en & global_irq_enable;
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rise;
    !compare_result ##1 compare_result;
  endsequence

  sequence s_fall;
    compare_result ##1 !compare_result;
  endsequence

  sequence s_flag_w1c;
    wr_csr && pwdata[BIT_FLAG] && !mode_event;
  endsequence

  result_sync_a: assert property (
    ##2 compare_result == $past(comparator_raw, 2))
    else $error("result does not follow comparator two cycles later");

  neg_mux_a: assert property (
    ##1 neg_from_converter == $past(ctlb.mux_en && !converter_enable))
    else $error("negative input selection wrong");

  bandgap_wr_a: assert property (
    wr_csr |=> bandgap_select == $past(pwdata[BIT_BANDGAP]))
    else $error("bandgap select did not take written value");

  power_wr_a: assert property (
    wr_csr |=> comparator_power_off == $past(pwdata[BIT_POWER_OFF]))
    else $error("power off did not take written value");

  rise_sets_a: assert property (
    s_rise ##0 (csr.mode == MODE_RISE) |=> csr.flag)
    else $error("rising edge missed in rise mode");

  fall_sets_a: assert property (
    s_fall ##0 (csr.mode == MODE_FALL || csr.mode == MODE_TOGGLE) |=> csr.flag)
    else $error("falling edge missed");

  rsvd_quiet_a: assert property (
    (csr.mode == MODE_RSVD) && !csr.flag && !wr_csr |=> !csr.flag)
    else $error("reserved mode set the flag");

  ack_clear_a: assert property (
    vector_ack && !mode_event |=> !csr.flag)
    else $error("vector acknowledge did not clear flag");

  flag_w1c_a: assert property (
    s_flag_w1c |=> !csr.flag)
    else $error("write one did not clear flag");

  flag_keep_a: assert property (
    wr_csr && !pwdata[BIT_FLAG] && !vector_ack && csr.flag |=> csr.flag)
    else $error("write zero disturbed flag");

  irq_gate_a: assert property (
    mode_event && csr.irq_en && !wr_csr |=> compare_irq == global_irq_enable)
    else $error("request does not follow flag, enable and global enable");

  capture_path_a: assert property (
    ##1 capture_trigger == $past(csr.capture_en && compare_result))
    else $error("capture trigger does not follow routed result");

  ctlb_rsvd_a: assert property (
    psel && !penable && !pwrite && paddr == CTLB_ADDR
      |=> prdata[7] == 1'b0 && prdata[5:3] == 3'h0 && prdata[6] == $past(ctlb.mux_en))
    else $error("control b readback wrong");

  csr_result_a: assert property (
    psel && !penable && !pwrite && paddr == CSR_ADDR
      |=> prdata[BIT_RESULT] == $past(compare_result))
    else $error("result bit readback wrong");

endmodule // analog_comparator_control

// file: core/acmp_pkg.sv
package acmp_pkg;

  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 12;
  typedef logic [ADDR_W-1:0] addr_t;

  // register indices; byte address is four times the index
  localparam logic [7:0] CSR_IDX = 8'h50;
  localparam logic [7:0] CTLB_IDX = 8'h7B;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h80;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h81;
  localparam addr_t CSR_ADDR = {2'h0, CSR_IDX, 2'h0};
  localparam addr_t CTLB_ADDR = {2'h0, CTLB_IDX, 2'h0};
  localparam addr_t IRQ_STAT_ADDR = {2'h0, IRQ_STAT_IDX, 2'h0};
  localparam addr_t IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_POWER_OFF = 7;
  localparam int BIT_BANDGAP = 6;
  localparam int BIT_RESULT = 5;
  localparam int BIT_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_CAPTURE = 2;
  localparam int BIT_MUX_EN = 6;
  localparam int IRQ_W = 2;
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_CHANGE = 1;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------
  // types and reset values
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'b00,
    MODE_RSVD = 2'b01,
    MODE_FALL = 2'b10,
    MODE_RISE = 2'b11
  } mode_t;

  typedef struct packed {
    logic power_off;
    logic bandgap;
    logic flag;
    logic irq_en;
    logic capture_en;
    mode_t mode;
  } csr_t;

  typedef struct packed {
    logic mux_en;
    logic [2:0] trig;
  } ctlb_t;

  localparam csr_t CSR_RESET = csr_t'(7'h00);
  localparam ctlb_t CTLB_RESET = ctlb_t'(4'h0);
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

endpackage

// file: core/sync_chain.sv
`timescale 1ns/1ps
module sync_chain #(
  parameter int STAGES = 2
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);
  logic [STAGES-1:0] stage;
  logic [STAGES-1:0] next_stage;

  // only the last stage is visible outside
  always_comb begin
    next_stage = {stage[STAGES-2:0], async_in};
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_out = stage[STAGES-1];
endmodule // sync_chain

// file: core/edge_detect.sv
`timescale 1ns/1ps
module edge_detect (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = level;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule // edge_detect

// file: tb/test_analog_comparator_control.sv
`timescale 1ns/1ps
module test_analog_comparator_control;
  import acmp_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  addr_t paddr;
  logic [31:0] pwdata, prdata, rd;
  logic comparator_raw, converter_enable, global_irq_enable, vector_ack;
  logic [2:0] channel_select, neg_channel, trigger_select;
  logic comparator_power_off, bandgap_select, neg_from_converter, capture_trigger;
  logic compare_irq, irq;
  logic [1:0] m;
  logic [7:0] f;
  int n_mismatch, n_checks;
  localparam logic [7:0] MODES = 8'b01_11_10_00;

  analog_comparator_control analog_comparator_control_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_raw(comparator_raw),
    .converter_enable(converter_enable), .channel_select(channel_select),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
    .comparator_power_off(comparator_power_off), .bandgap_select(bandgap_select),
    .neg_from_converter(neg_from_converter), .neg_channel(neg_channel),
    .capture_trigger(capture_trigger), .trigger_select(trigger_select),
    .compare_irq(compare_irq), .irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one edge first, so a release and the next setup never share a time step
  task apb(input logic wr, input addr_t a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input addr_t a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    comparator_raw = 1'b0;
    converter_enable = 1'b0;
    channel_select = 3'h0;
    global_irq_enable = 1'b0;
    vector_ack = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdchk(CSR_ADDR, 32'h0);
    rdchk(CTLB_ADDR, 32'h0);
    apb(1'b1, CTLB_ADDR, 32'hFF);
    rdchk(CTLB_ADDR, 32'h47);
    chk(32'(trigger_select), 32'h7);
    apb(1'b1, CSR_ADDR, 32'hF7);
    rdchk(CSR_ADDR, 32'hC7);
    chk(32'({comparator_power_off, bandgap_select}), 32'h3);
    apb(1'b1, CSR_ADDR, 32'h0);
    wait_n(1);
    chk(32'({comparator_power_off, bandgap_select}), 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    channel_select <= 3'h5;
    apb(1'b1, CTLB_ADDR, 32'h40);
    wait_n(2);
    chk(32'({neg_from_converter, neg_channel}), 32'hD);
    converter_enable <= 1'b1;
    wait_n(2);
    chk(32'({neg_from_converter, neg_channel}), 32'h0);
    $display("test input steering done");
    // reserved code last, so it also starts from a low comparator
    for (int i = 0; i < 4; i++) begin
      m = MODES[2*i +: 2];
      apb(1'b1, CSR_ADDR, 32'(8'h10 | m));
      comparator_raw <= 1'b1;
      wait_n(4);
      f = (m == MODE_TOGGLE || m == MODE_RISE) ? 8'h30 : 8'h20;
      rdchk(CSR_ADDR, 32'(f | m));
      apb(1'b1, CSR_ADDR, 32'(8'h10 | m));
      comparator_raw <= 1'b0;
      wait_n(4);
      f = (m == MODE_TOGGLE || m == MODE_FALL) ? 8'h10 : 8'h00;
      rdchk(CSR_ADDR, 32'(f | m));
    end
    $display("test event modes done");
    global_irq_enable <= 1'b1;
    apb(1'b1, CSR_ADDR, 32'h07);
    apb(1'b1, CSR_ADDR, 32'h0F);
    comparator_raw <= 1'b1;
    wait_n(4);
    chk(32'({compare_irq, capture_trigger}), 32'h3);
    apb(1'b1, CSR_ADDR, 32'h07);
    wait_n(1);
    chk(32'(compare_irq), 32'h0);
    rdchk(CSR_ADDR, 32'h37);
    apb(1'b1, CSR_ADDR, 32'h0F);
    wait_n(1);
    chk(32'(compare_irq), 32'h1);
    global_irq_enable <= 1'b0;
    wait_n(2);
    chk(32'(compare_irq), 32'h0);
    global_irq_enable <= 1'b1;
    vector_ack <= 1'b1;
    @(posedge ref_clk);
    vector_ack <= 1'b0;
    wait_n(2);
    rdchk(CSR_ADDR, 32'h2F);
    apb(1'b1, CSR_ADDR, 32'h0B);
    wait_n(2);
    chk(32'(capture_trigger), 32'h0);
    $display("test request and capture done");
    apb(1'b1, IRQ_STAT_ADDR, 32'h3);
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    rdchk(IRQ_MASK_ADDR, 32'h1);
    rdchk(IRQ_STAT_ADDR, 32'h0);
    comparator_raw <= 1'b0;
    wait_n(4);
    chk(32'(irq), 32'h0);
    rdchk(IRQ_STAT_ADDR, 32'h2);
    comparator_raw <= 1'b1;
    wait_n(4);
    chk(32'(irq), 32'h1);
    apb(1'b1, IRQ_MASK_ADDR, 32'h0);
    wait_n(1);
    chk(32'(irq), 32'h0);
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    apb(1'b1, IRQ_STAT_ADDR, 32'h1);
    wait_n(1);
    chk(32'(irq), 32'h0);
    rdchk(IRQ_STAT_ADDR, 32'h2);
    $display("test interrupt registers done");
    end_of_test;
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test;
  end
endmodule // test_analog_comparator_control
